// >>> core/aosp_pkg.sv
package aosp_pkg;

  // Result and bus geometry
  localparam int RES_W = 18;
  localparam int CNT_W = $clog2(RES_W + 1);
  localparam int AXI_AW = 4;
  localparam int DIV_W = 4;

  // Register byte offsets
  localparam logic [AXI_AW-1:0] REG_CTRL = 4'h0;
  localparam logic [AXI_AW-1:0] REG_STATUS = 4'h4;
  localparam logic [AXI_AW-1:0] REG_RESULT = 4'h8;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SRC_BIT = 2;
  localparam int CTRL_FMT_BIT = 3;
  localparam int CTRL_DIV_LSB = 8;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0F0F;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // Status register fields
  localparam int STAT_FRAME_BIT = 0;
  localparam int STAT_FSM_LSB = 1;
  localparam int STAT_SLAVE_BIT = 3;
  localparam int STAT_CNT_LSB = 8;
  localparam int STAT_FRAMES_LSB = 16;

  // Interface mode that turns the shared pins serial
  localparam logic [1:0] MODE_SERIAL = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Shared pin positions: index 0 is par_bit_7 ... index 3 is par_bit_10
  localparam int PIN_SYNC_POL = 0;
  localparam int PIN_EDGE = 1;
  localparam int PIN_RD_TIMING = 2;
  localparam int PIN_SDO = 3;
  localparam int NPIN = 4;
  localparam int PAR_LSB = 7;

  // Master clock quarter phases: the two where the uninverted generated clock is high, then the last (low)
  localparam logic [1:0] PH_HI_A = 2'h1;
  localparam logic [1:0] PH_HI_B = 2'h2;
  localparam logic [1:0] PH_LAST = 2'h3;

  typedef enum logic [1:0] {
    AOSP_IDLE,
    AOSP_MSHIFT,
    AOSP_SSHIFT
  } aosp_fsm_t;

  // Conversion engine handoff, same clock domain
  typedef struct packed {
    logic start;
    logic done;
    logic [RES_W-1:0] data;
  } aosp_conv_t;

  // One shared pin group: input, output, output enable
  typedef struct packed {
    logic [NPIN-1:0] i;
  } aosp_pin_in_t;

  typedef struct packed {
    logic [NPIN-1:0] o;
    logic [NPIN-1:0] oe;
  } aosp_pin_out_t;

  typedef struct packed {
    // Register slave
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    logic [AXI_AW-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    // Serial engine
    aosp_fsm_t fsm;
    logic [RES_W-1:0] stored;
    logic [RES_W-1:0] shreg;
    logic [CNT_W-1:0] bitcnt;
    logic [DIV_W-1:0] qcnt;
    logic [1:0] phase;
    logic frame;
    logic [15:0] frames;
    logic sclk_prev;
    logic cs_prev;
    // Pin drivers
    logic sclk_o;
    logic sclk_oe;
    logic sync_o;
    logic [NPIN-1:0] pin_o;
    logic [NPIN-1:0] pin_oe;
  } aosp_state_t;

endpackage

// >>> core/aosp_sync2.sv
`timescale 1ns/10ps
module aosp_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Levels from outside the clock domain
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // aosp_sync2

// >>> core/aosp_serial_port.sv
`timescale 1ns/10ps
module aosp_serial_port
  import aosp_pkg::*;
#(
  parameter int CHAIN_DELAY = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [aosp_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [aosp_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Conversion engine
  input wire aosp_pkg::aosp_conv_t conv,
  // Shared pins par_bit_7 .. par_bit_10
  input wire aosp_pkg::aosp_pin_in_t par_pins_in,
  output aosp_pkg::aosp_pin_out_t par_pins_out,
  // Serial data clock pin
  input wire logic serial_data_clock_i,
  output logic serial_data_clock_o,
  output logic serial_data_clock_oe,
  // Frame sync and chip select
  output logic frame_sync,
  input wire logic chip_sel_n
);

  import aosp_pkg::*;

  if (CHAIN_DELAY < 1 || CHAIN_DELAY > RES_W) begin : g_bad_chain
    $error("CHAIN_DELAY must lie between 1 and the result width");
  end

  // The parallel slice and the divider must fit the package geometry
  if (RES_W < PAR_LSB + NPIN || DIV_W < 1) begin : g_bad_geom
    $error("Result too narrow for the shared parallel pins");
  end

  // Bit position where chained data enters so it reaches the MSB on time
  localparam int CHAIN_POS = RES_W - CHAIN_DELAY;
  localparam int NSYNC = NPIN - 1 + 2;
  localparam int SY_SCLK = NPIN - 1;
  localparam int SY_CS = NPIN;
  // Chip select idles high, everything else low
  localparam logic [NSYNC-1:0] SYNC_RST = {1'b1, {(NSYNC - 1){1'b0}}};
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(RES_W - 1);
  localparam logic [CNT_W-1:0] MAX_CNT = CNT_W'(RES_W);

  aosp_state_t q;
  aosp_state_t n;
  logic [NSYNC-1:0] sync_lv;

  // Result coding: format select high keeps offset binary, low flips MSB
  function automatic logic [RES_W-1:0] aosp_code(input logic [RES_W-1:0] raw, input logic fmt);
    logic [RES_W-1:0] r;
    r = raw;
    r[RES_W-1] = raw[RES_W-1] ^ ~fmt;
    return r;
  endfunction

  // Shift toward MSB, placing one bit at a chosen position
  function automatic logic [RES_W-1:0] aosp_shift(input logic [RES_W-1:0] v, input logic ins,
                                                  input int pos);
    logic [RES_W-1:0] r;
    r = {v[RES_W-2:0], 1'b0};
    r[pos] = ins;
    return r;
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] aosp_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Pins, external clock and select all come from outside the domain
  aosp_sync2 #(
    .W(NSYNC),
    .RST_VAL(SYNC_RST)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({chip_sel_n, serial_data_clock_i, par_pins_in.i[NPIN-2:0]}),
    .sync_out(sync_lv)
  );

  logic [1:0] mode;
  logic src_ext;
  logic fmt_sel;
  logic [DIV_W-1:0] div;
  logic serial;
  logic master;
  logic slave;
  logic sync_polarity_sel;
  logic clock_edge_sel;
  logic read_timing_sel;
  logic chain_data_in;
  logic sclk_s;
  logic cs_n_s;
  logic sclk_rise;
  logic sclk_fall;
  logic act_edge;
  logic cs_fall;
  // Coded result seen on the parallel pins
  logic [RES_W-1:0] par_word;

  always_comb begin
    mode = q.ctrl[CTRL_MODE_LSB +: 2];
    src_ext = q.ctrl[CTRL_SRC_BIT];
    fmt_sel = q.ctrl[CTRL_FMT_BIT];
    div = q.ctrl[CTRL_DIV_LSB +: DIV_W];
    serial = (mode == MODE_SERIAL);
    master = serial && !src_ext;
    slave = serial && src_ext;
    sync_polarity_sel = sync_lv[PIN_SYNC_POL];
    clock_edge_sel = sync_lv[PIN_EDGE];
    read_timing_sel = sync_lv[PIN_RD_TIMING];
    // Same pin serves as chain input in slave mode
    chain_data_in = sync_lv[PIN_RD_TIMING];
    sclk_s = sync_lv[SY_SCLK];
    cs_n_s = sync_lv[SY_CS];
    sclk_rise = sclk_s && !q.sclk_prev;
    sclk_fall = !sclk_s && q.sclk_prev;
    act_edge = clock_edge_sel ? sclk_fall : sclk_rise;
    cs_fall = !cs_n_s && q.cs_prev;
  end

  always_comb begin
    n = q;

    // Write channel: address and data in either order
    if (s_axi_awvalid && q.aw_rdy) begin
      n.aw_rdy = 1'b0;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.w_rdy) begin
      n.w_rdy = 1'b0;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (!q.aw_rdy && !q.w_rdy && !q.bvalid) begin
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      if (q.aw_addr == REG_CTRL) begin
        n.ctrl = aosp_merge(q.ctrl, q.w_data, q.w_strb) & CTRL_MASK;
      end else if (q.aw_addr == REG_STATUS || q.aw_addr == REG_RESULT) begin
        // Read-only registers ignore the data but still answer OKAY
        n.bresp = RESP_OKAY;
      end else begin
        n.bresp = RESP_SLVERR;
      end
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
      n.aw_rdy = 1'b1;
      n.w_rdy = 1'b1;
    end

    // Read channel: one outstanding read, answer on the next edge
    if (s_axi_arvalid && q.ar_rdy) begin
      n.ar_rdy = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = '0;
      if (s_axi_araddr == REG_CTRL) begin
        n.rdata = q.ctrl;
      end else if (s_axi_araddr == REG_STATUS) begin
        n.rdata[STAT_FRAME_BIT] = q.frame;
        n.rdata[STAT_FSM_LSB +: 2] = q.fsm;
        n.rdata[STAT_SLAVE_BIT] = slave;
        n.rdata[STAT_CNT_LSB +: CNT_W] = q.bitcnt;
        n.rdata[STAT_FRAMES_LSB +: 16] = q.frames;
      end else if (s_axi_araddr == REG_RESULT) begin
        n.rdata[RES_W-1:0] = q.stored;
      end else begin
        n.rresp = RESP_SLVERR;
      end
    end
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
      n.ar_rdy = 1'b1;
    end

    n.sclk_prev = sclk_s;
    n.cs_prev = cs_n_s;

    // On-chip result register
    if (conv.done) begin
      n.stored = conv.data;
    end

    case (q.fsm)
      AOSP_IDLE: begin
        // Only an idle engine takes a trigger; later ones are dropped
        n.bitcnt = '0;
        n.qcnt = '0;
        n.phase = '0;
        if (master && !read_timing_sel && conv.done) begin
          n.shreg = aosp_code(conv.data, fmt_sel);
          n.frame = 1'b1;
          n.fsm = AOSP_MSHIFT;
        end else if (master && read_timing_sel && conv.start) begin
          n.shreg = aosp_code(q.stored, fmt_sel);
          n.frame = 1'b1;
          n.fsm = AOSP_MSHIFT;
        end else if (slave && cs_fall) begin
          n.shreg = aosp_code(q.stored, fmt_sel);
          n.frame = 1'b1;
          n.fsm = AOSP_SSHIFT;
        end
      end
      AOSP_MSHIFT: begin
        // Leaving master mode cuts the frame short
        if (!master) begin
          n.frame = 1'b0;
          n.fsm = AOSP_IDLE;
        end else if (q.qcnt == div) begin
          n.qcnt = '0;
          n.phase = q.phase + 2'h1;
          // Bit changes only after both clock edges of its period
          if (q.phase == PH_LAST) begin
            if (q.bitcnt == LAST_BIT) begin
              n.frame = 1'b0;
              n.frames = q.frames + 16'h0001;
              n.fsm = AOSP_IDLE;
            end else begin
              n.shreg = aosp_shift(q.shreg, 1'b0, 0);
              n.bitcnt = q.bitcnt + CNT_W'(1);
            end
          end
        end else begin
          n.qcnt = q.qcnt + DIV_W'(1);
        end
      end
      AOSP_SSHIFT: begin
        // Select release ends the frame wherever the host stopped
        if (!slave || cs_n_s) begin
          n.frame = 1'b0;
          n.frames = q.frames + 16'h0001;
          n.fsm = AOSP_IDLE;
        end else if (act_edge) begin
          // Pin edges arrive three cycles late; the host clock must stay
          // at each level for at least three cycles
          n.shreg = aosp_shift(q.shreg, chain_data_in, CHAIN_POS);
          if (q.bitcnt != MAX_CNT) begin
            n.bitcnt = q.bitcnt + CNT_W'(1);
          end
        end
      end
      default: begin
        n.fsm = AOSP_IDLE;
      end
    endcase

    // Generated clock: low, high, high, low per bit, then inverted on request
    n.sclk_o = (n.fsm == AOSP_MSHIFT) && (n.phase == PH_HI_A || n.phase == PH_HI_B);
    n.sclk_o = n.sclk_o ^ clock_edge_sel;
    n.sclk_oe = master;
    n.sync_o = (master && n.frame) ? !sync_polarity_sel : sync_polarity_sel;

    par_word = aosp_code(n.stored, fmt_sel);
    if (serial) begin
      n.pin_o = '0;
      n.pin_o[PIN_SDO] = n.shreg[RES_W-1];
      n.pin_oe = '0;
      n.pin_oe[PIN_SDO] = 1'b1;
    end else begin
      n.pin_o = par_word[PAR_LSB +: NPIN];
      n.pin_oe = '1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.aw_rdy <= 1'b1;
      q.w_rdy <= 1'b1;
      q.ar_rdy <= 1'b1;
      q.ctrl <= CTRL_RST;
      q.fsm <= AOSP_IDLE;
      q.cs_prev <= 1'b1;
      q.pin_oe <= '1;
    end else begin
      q <= n;
    end
  end

  // Every output straight from the state register
  assign s_axi_awready = q.aw_rdy;
  assign s_axi_wready = q.w_rdy;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.ar_rdy;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign par_pins_out.o = q.pin_o;
  assign par_pins_out.oe = q.pin_oe;
  assign serial_data_clock_o = q.sclk_o;
  assign serial_data_clock_oe = q.sclk_oe;
  assign frame_sync = q.sync_o;

endmodule // aosp_serial_port

// >>> tb/aosp_sva.sv
`timescale 1ns/10ps
module aosp_sva
  import aosp_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire aosp_pkg::aosp_pin_out_t par_pins_out,
  input wire logic serial_data_clock_o,
  input wire logic serial_data_clock_oe,
  input wire logic frame_sync
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  sequence clk_toggle;
    serial_data_clock_oe && $past(serial_data_clock_oe) && $changed(serial_data_clock_o);
  endsequence

  rst_idle_a: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !serial_data_clock_oe)
    else $error("outputs busy after reset");
  b_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  pin_dir_a: assert property (serial_data_clock_oe |-> par_pins_out.oe == 4'h8)
    else $error("pin direction wrong in master mode");
  bit_steady_a: assert property (clk_toggle and $stable(frame_sync) |-> $stable(par_pins_out.o[3]))
    else $error("data moved on a clock edge");
  clk_phase_a: assert property (clk_toggle |=> !serial_data_clock_oe || $stable(serial_data_clock_o))
    else $error("clock phase too short");
endmodule // aosp_sva

// >>> tb/aosp_host.sv
`timescale 1ns/10ps
module aosp_host (
  // Clock
  input wire logic aclk,
  // Device side
  input wire logic sclk_o,
  input wire logic sync,
  input wire logic sdo,
  input wire logic pol,
  input wire logic esel,
  // Host drives
  output logic sclk_ext,
  output logic cs_n,
  output logic chain
);
  initial begin
    sclk_ext = 0;
    cs_n = 1;
    chain = 0;
  end

  // Takes a bit on each active edge while sync is active
  task automatic master_rx(output logic [17:0] w, output int n);
    logic prev;
    n = 0;
    prev = sclk_o;
    for (int i = 0; i < 400 && n < 18; i++) begin
      @(posedge aclk);
      if (sclk_o !== prev && sclk_o === !esel && sync === !pol) begin
        w = {w[16:0], sdo};
        n++;
      end
      prev = sclk_o;
    end
  endtask

  // Clock stands at idle level outside the selected frame
  task automatic slave_rx(input logic [17:0] ch, output logic [17:0] w);
    sclk_ext <= esel;
    repeat (10) @(posedge aclk);
    cs_n <= 0;
    for (int i = 0; i < 18; i++) begin
      chain <= ch[17-i];
      repeat (10) @(posedge aclk);
      w = {w[16:0], sdo};
      sclk_ext <= !esel;
      repeat (10) @(posedge aclk);
      sclk_ext <= esel;
    end
    repeat (10) @(posedge aclk);
    cs_n <= 1;
    chain <= ~chain;
  endtask
endmodule // aosp_host

// >>> tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import aosp_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [3:0] s_axi_awaddr = '0;
  logic [3:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  aosp_conv_t conv = '0;
  aosp_pin_in_t par_pins_in;
  aosp_pin_out_t par_pins_out;
  logic serial_data_clock_i, serial_data_clock_o, serial_data_clock_oe, frame_sync, chip_sel_n;
  logic pol = 0, esel = 0, rdt = 0, slave = 0, sclk_ext, chain;
  logic [31:0] seed = 32'h0001_5EB0;
  int fails = 0;
  int n_checks = 0;

  // Wire levels follow whichever party enables its driver
  assign serial_data_clock_i = serial_data_clock_oe ? serial_data_clock_o : sclk_ext;
  assign par_pins_in.i = (par_pins_out.oe & par_pins_out.o) | (~par_pins_out.oe & {1'b0, slave ? chain : rdt, esel, pol});

  always #4 aclk = ~aclk;

  aosp_serial_port DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .conv, .par_pins_in, .par_pins_out, .serial_data_clock_i, .serial_data_clock_o, .serial_data_clock_oe,
    .frame_sync, .chip_sel_n);

  aosp_host HOST (.aclk, .sclk_o(serial_data_clock_o), .sync(frame_sync), .sdo(par_pins_out.o[3]), .pol, .esel,
    .sclk_ext, .cs_n(chip_sel_n), .chain);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [17:0] coded(input logic [17:0] d, input logic f);
    return f ? d : {~d[17], d[16:0]};
  endfunction

  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    logic got;
    got = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    for (i = 0; i < 100 && !got; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 0;
        got = 1;
      end else if (s_axi_bvalid) begin
        s_axi_bready <= 1;
      end
    end
    if (!got) begin
      check(0, 1, "write timeout");
      finish_test();
    end
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    logic got;
    got = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    for (i = 0; i < 100 && !got; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
        got = 1;
      end else if (s_axi_rvalid) begin
        s_axi_rready <= 1;
      end
    end
    if (!got) begin
      check(0, 1, "read timeout");
      finish_test();
    end
  endtask

  task automatic pulse(input logic st, input logic [17:0] d);
    @(posedge aclk);
    conv.data <= d;
    conv.start <= st;
    conv.done <= !st;
    @(posedge aclk);
    conv.start <= 0;
    conv.done <= 0;
  endtask

  initial begin
    logic [31:0] v, q;
    logic [17:0] d, e, w, ch;
    logic [1:0] r;
    logic f;
    int n;
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    axi_rd(REG_CTRL, q, r);
    check({q, r}, {CTRL_RST, RESP_OKAY}, "ctrl reset");
    v = rnd();
    axi_wr(REG_CTRL, v, r);
    axi_rd(REG_CTRL, q, r);
    check(q, v & CTRL_MASK, "ctrl readback");
    axi_wr(4'hC, v, r);
    check(r, RESP_SLVERR, "unmapped write");
    axi_rd(4'hC, q, r);
    check({q, r}, {32'h0000_0000, RESP_SLVERR}, "unmapped read");
    for (int k = 0; k < 3; k++) begin
      v = rnd();
      f = v[0];
      d = v[31:14];
      e = coded(d, f);
      axi_wr(REG_CTRL, {28'h0, f, 1'b0, k[1:0]}, r);
      pulse(1'b0, d);
      repeat (3) @(posedge aclk);
      check({par_pins_out.oe, par_pins_out.o}, {4'hF, e[10:7]}, "parallel bits");
      axi_rd(REG_RESULT, q, r);
      check({q, r}, {14'h0, d, RESP_OKAY}, "result register");
    end
    for (int k = 0; k < 4; k++) begin
      v = rnd();
      f = v[0];
      d = v[31:14];
      e = coded(d, f);
      pol <= k[0];
      esel <= k[1];
      rdt <= 0;
      axi_wr(REG_CTRL, {28'h0, f, 3'h3}, r);
      repeat (4) @(posedge aclk);
      fork
        HOST.master_rx(w, n);
        pulse(1'b0, d);
      join
      check({n, w}, {32'd18, e}, "master after");
      repeat (4) @(posedge aclk);
      check(frame_sync, pol, "sync idle");
      rdt <= 1;
      repeat (4) @(posedge aclk);
      fork
        HOST.master_rx(w, n);
        pulse(1'b1, ~d);
      join
      check({n, w}, {32'd18, e}, "master during");
    end
    repeat (4) @(posedge aclk);
    axi_rd(REG_STATUS, q, r);
    check({q, r}, {32'h0008_0000, RESP_OKAY}, "status after master");
    for (int k = 0; k < 2; k++) begin
      v = rnd();
      ch = v[17:0];
      esel <= k[0];
      slave <= 1;
      axi_wr(REG_CTRL, {28'h0, f, 3'h7}, r);
      HOST.slave_rx(ch, w);
      check(w, {e[17:2], ch[17:16]}, "slave chain");
    end
    repeat (4) @(posedge aclk);
    axi_rd(REG_STATUS, q, r);
    check({q, r}, {32'h000A_0008, RESP_OKAY}, "status after slave");
    finish_test();
  end
endmodule // tb_top

bind aosp_serial_port aosp_sva SVA (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .par_pins_out, .serial_data_clock_o, .serial_data_clock_oe, .frame_sync);
